/* rtl/su2_defines.vh */
`ifndef SU2_DEFINES_VH
`define SU2_DEFINES_VH
// Register addresses
`define SU2_ADDR_STATUS 16'h0370
`define SU2_ADDR_MASK 16'h0371
`define SU2_ADDR_MODE 16'h0378
`define SU2_ADDR_BAUD 16'h0379
`define SU2_ADDR_TXBUF 16'h037a
`define SU2_ADDR_CTRL0 16'h037c
`define SU2_ADDR_CTRL1 16'h037d
`define SU2_ADDR_RXBUF 16'h037e
// Control zero fields
`define SU2_C0_SRC_LO 0
`define SU2_C0_SRC_HI 1
`define SU2_C0_HS_SEL 2
`define SU2_C0_SHIFT_EMPTY 3
`define SU2_C0_HS_DIS 4
`define SU2_C0_POL 6
`define SU2_C0_ORDER 7
// Control one fields
`define SU2_C1_TE 0
`define SU2_C1_HOLD_EMPTY 1
`define SU2_C1_RE 2
`define SU2_C1_RX_DONE 3
`define SU2_C1_IRS 4
`define SU2_C1_CONT 5
`define SU2_C1_INV 6
`define SU2_C1_ERE 7
// Mode field and codes
`define SU2_MODE_CLOCK_DIRECTION_SELECT 3
`define SU2_MODE_OFF 3'h0
`define SU2_MODE_SYNC 3'h1
`define SU2_MODE_A7 3'h4
`define SU2_MODE_A8 3'h5
`define SU2_MODE_A9 3'h6
// Status and mask fields
`define SU2_ST_TX 0
`define SU2_ST_RX 1
`define SU2_ST_OVR 2
`define SU2_ST_FRM 3
// Reset values and continuous-receive dummy byte
`define SU2_RST_REG8 8'h00
`define SU2_RST_REG4 4'h0
`define SU2_DUMMY_TX 8'hff
// Timing counts
`define SU2_DIV8_LAST 3'h7
`define SU2_DIV32_LAST 5'h1f
`define SU2_OVS_MID 4'h7
`define SU2_OVS_LAST 4'hf
`endif

/* rtl/su2_serial_ctrl.v */
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "su2_defines.vh"

// Operation
// - Count source 00/01/10 clocks generator at f1, f8, f32; 11 stops it.
// - Shift empty flag reads 0 while shifting, 1 when transmission done.
// - Handshake disable 1 turns handshake off and releases the pin.
// - Control zero bit 5 is unused; write 0, always reads 0.
// - Clocked mode polarity 0 drives falling, samples rising; 1 reverses.
// - Bit order 0 sends least significant bit first, 1 most first.
// - Transmit enable 0 blocks transmission, 1 permits it.
// - Holding empty flag reads 0 with a pending byte, 1 when empty.
// - Receive enable 0 blocks reception, 1 permits it.
// - Receive complete flag reads 1 while unread data is held.
// - Transmit interrupt on buffer empty if cause 0, frame done if 1.
// - Continuous receive works only in clocked mode, ignored in async.
// - Data invert 1 inverts buffer data in both modes.
// - Error output enable gates error output in async mode only.
// - Mode 001 clocked, 100/101/110 async 7/8/9 bits, 000 off.
// - Clock direction 0 uses internal generator, 1 the clock pin; async modes always use the internal generator.
module su2_serial_ctrl #(
  parameter BAUD_W = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire rxd,
  output reg txd,
  input wire clk_pin_in,
  output reg clk_pin_out,
  output reg clk_pin_oe,
  input wire hs_pin_in,
  output reg hs_pin_out,
  output reg hs_pin_oe,
  output reg hs_port_released,
  output reg err_out,
  output reg irq
);

  localparam T_IDLE = 2'h0;
  localparam T_START = 2'h1;
  localparam T_DATA = 2'h2;
  localparam T_STOP = 2'h3;

  reg count_source_sel_lo;
  reg count_source_sel_hi;
  reg handshake_select;
  reg handshake_disable;
  reg transfer_edge_polarity;
  reg bit_order_select;
  reg shift_reg_empty;
  reg transmit_enable_bit;
  reg holding_buffer_empty;
  reg receive_enable_bit;
  reg receive_complete;
  reg tx_irq_cause_select;
  reg continuous_receive_enable;
  reg data_invert_select;
  reg error_output_enable;
  reg [2:0] serial_mode;
  reg clock_direction_select;
  reg [BAUD_W-1:0] brg_value;
  reg [BAUD_W-1:0] brg_cnt;
  reg [4:0] pre;
  reg [7:0] tx_hold;
  reg [7:0] rx_buf;
  reg frame_err;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [1:0] tx_state;
  reg [8:0] tx_sh;
  reg [3:0] tx_cnt;
  reg [3:0] tx_tick;
  reg sck;
  reg clk_prev;
  reg [1:0] rx_state;
  reg [8:0] rx_sh;
  reg [3:0] rx_cnt;
  reg [3:0] rx_tick;

  function [7:0] su2_align;
    input [8:0] v;
    input [3:0] len;
    input msb;
    reg [8:0] sh;
    begin
      sh = v >> (4'h9 - len);
      su2_align = msb ? v[7:0] : sh[7:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode and mode

  wire wr_c0 = bus_wr && bus_addr == `SU2_ADDR_CTRL0;
  wire wr_c1 = bus_wr && bus_addr == `SU2_ADDR_CTRL1;
  wire wr_mode = bus_wr && bus_addr == `SU2_ADDR_MODE;
  wire wr_baud = bus_wr && bus_addr == `SU2_ADDR_BAUD;
  wire wr_tx = bus_wr && bus_addr == `SU2_ADDR_TXBUF;
  wire wr_st = bus_wr && bus_addr == `SU2_ADDR_STATUS;
  wire wr_mask = bus_wr && bus_addr == `SU2_ADDR_MASK;
  wire rd_rx = bus_rd && bus_addr == `SU2_ADDR_RXBUF;

  // Mode decode
  // mode codes
  wire sync_mode = serial_mode == `SU2_MODE_SYNC;
  wire a7 = serial_mode == `SU2_MODE_A7;
  wire a9 = serial_mode == `SU2_MODE_A9;
  wire async_mode = a7 || a9 || serial_mode == `SU2_MODE_A8;
  wire [3:0] frame_len = a7 ? 4'h7 : (a9 ? 4'h9 : 4'h8);

  ////////////////////////////////////////////////////////////////////
  // Baud-rate generator

  wire [1:0] src_sel = {count_source_sel_hi, count_source_sel_lo};
  reg src_tick;
  always @* begin
    case (src_sel)
      2'b00: src_tick = 1'b1;
      2'b01: src_tick = pre[2:0] == `SU2_DIV8_LAST;
      2'b10: src_tick = pre == `SU2_DIV32_LAST;
      default: src_tick = 1'b0;
    endcase
  end
  wire brg_tick = src_tick && brg_cnt == {BAUD_W{1'b0}};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre <= 5'h00;
      brg_cnt <= {BAUD_W{1'b0}};
    end else begin
      pre <= pre + 5'h01;
      if (brg_tick)
        brg_cnt <= brg_value;
      else if (src_tick)
        brg_cnt <= brg_cnt - {{(BAUD_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer clock edges and start conditions

  wire idle_lvl = ~transfer_edge_polarity;
  wire sync_busy = sync_mode && tx_state == T_DATA;
  // drive and sample edges by polarity
  wire drive_edge = clock_direction_select ?
    (clk_prev == idle_lvl && clk_pin_in != idle_lvl) :
    (brg_tick && sck == idle_lvl);
  wire sample_edge = clock_direction_select ?
    (clk_prev != idle_lvl && clk_pin_in == idle_lvl) :
    (brg_tick && sck != idle_lvl);

  wire cts_ok = handshake_disable || handshake_select || !hs_pin_in;
  wire ext_ok = !sync_mode || !clock_direction_select ||
    clk_pin_in == idle_lvl;
  wire tx_start = tx_state == T_IDLE && (sync_mode || async_mode) &&
    transmit_enable_bit && !holding_buffer_empty && cts_ok && ext_ok;

  wire tx_bit = bit_order_select ? tx_sh[8] : tx_sh[0];
  wire [8:0] tx_load = bit_order_select ?
    (a7 ? {tx_hold[6:0], 2'b00} :
      (a9 ? {1'b0, tx_hold} : {tx_hold, 1'b0})) :
    {1'b0, tx_hold};
  wire [8:0] sync_next = bit_order_select ?
    {tx_sh[7:0], rxd} : {rxd, tx_sh[8:1]};
  wire [8:0] tx_next = bit_order_select ?
    {tx_sh[7:0], 1'b1} : {1'b1, tx_sh[8:1]};
  wire tx_next_bit = bit_order_select ? tx_next[8] : tx_next[0];
  wire [8:0] rx_next = bit_order_select ?
    {rx_sh[7:0], rxd} : {rxd, rx_sh[8:1]};

  wire sync_done = sync_busy && sample_edge && tx_cnt == 4'h7;
  wire async_tx_done = tx_state == T_STOP && brg_tick &&
    tx_tick == `SU2_OVS_LAST;
  wire rx_stop = rx_state == T_STOP && brg_tick &&
    rx_tick == `SU2_OVS_LAST;

  wire rx_done = receive_enable_bit && (sync_done || rx_stop);
  wire [7:0] rx_word = sync_done ?
    su2_align(sync_next, 4'h8, bit_order_select) :
    su2_align(rx_sh, frame_len, bit_order_select);
  // Read in the same cycle frees the buffer: new byte wins
  wire rx_ok = rx_done && (!receive_complete || rd_rx);
  wire ovr_evt = rx_done && receive_complete && !rd_rx;
  wire frm_evt = rx_stop && receive_enable_bit && !rxd;
  wire tx_evt = tx_irq_cause_select ?
    (sync_done || async_tx_done) : tx_start;
  wire cont_arm = sync_mode && continuous_receive_enable && rd_rx &&
    holding_buffer_empty;

  wire [3:0] events = {frm_evt, ovr_evt, rx_ok, tx_evt};
  wire [3:0] st_clr = wr_st ? bus_wdata[3:0] : 4'h0;
  wire [3:0] next_status = (irq_status & ~st_clr) | events;

  ////////////////////////////////////////////////////////////////////
  // Software registers and flags

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_source_sel_lo <= 1'b0;
      count_source_sel_hi <= 1'b0;
      handshake_select <= 1'b0;
      handshake_disable <= 1'b0;
      transfer_edge_polarity <= 1'b0;
      bit_order_select <= 1'b0;
      transmit_enable_bit <= 1'b0;
      receive_enable_bit <= 1'b0;
      tx_irq_cause_select <= 1'b0;
      continuous_receive_enable <= 1'b0;
      data_invert_select <= 1'b0;
      error_output_enable <= 1'b0;
      serial_mode <= `SU2_MODE_OFF;
      clock_direction_select <= 1'b0;
      brg_value <= {BAUD_W{1'b0}};
      tx_hold <= `SU2_RST_REG8;
      rx_buf <= `SU2_RST_REG8;
      holding_buffer_empty <= 1'b1;
      receive_complete <= 1'b0;
      frame_err <= 1'b0;
      irq_status <= `SU2_RST_REG4;
      irq_mask <= `SU2_RST_REG4;
    end else begin
      if (wr_c0) begin
        count_source_sel_lo <= bus_wdata[`SU2_C0_SRC_LO];
        count_source_sel_hi <= bus_wdata[`SU2_C0_SRC_HI];
        handshake_select <= bus_wdata[`SU2_C0_HS_SEL];
        handshake_disable <= bus_wdata[`SU2_C0_HS_DIS];
        transfer_edge_polarity <= bus_wdata[`SU2_C0_POL];
        bit_order_select <= bus_wdata[`SU2_C0_ORDER];
      end
      if (wr_c1) begin
        transmit_enable_bit <= bus_wdata[`SU2_C1_TE];
        receive_enable_bit <= bus_wdata[`SU2_C1_RE];
        tx_irq_cause_select <= bus_wdata[`SU2_C1_IRS];
        continuous_receive_enable <= bus_wdata[`SU2_C1_CONT];
        data_invert_select <= bus_wdata[`SU2_C1_INV];
        error_output_enable <= bus_wdata[`SU2_C1_ERE];
      end
      if (wr_mode) begin
        serial_mode <= bus_wdata[2:0];
        clock_direction_select <= bus_wdata[`SU2_MODE_CLOCK_DIRECTION_SELECT];
      end
      if (wr_baud)
        brg_value <= bus_wdata[BAUD_W-1:0];
      if (wr_mask)
        irq_mask <= bus_wdata[3:0];
      // load to shifter empties holding buffer
      if (tx_start)
        holding_buffer_empty <= 1'b1;
      if (cont_arm) begin
        tx_hold <= `SU2_DUMMY_TX;
        holding_buffer_empty <= 1'b0;
      end
      if (wr_tx) begin
        tx_hold <= bus_wdata ^ {8{data_invert_select}};
        holding_buffer_empty <= 1'b0;
      end
      if (rd_rx) begin
        receive_complete <= 1'b0;
        frame_err <= 1'b0;
      end
      if (rx_ok) begin
        rx_buf <= rx_word;
        receive_complete <= 1'b1;
      end
      if (frm_evt)
        frame_err <= 1'b1;
      irq_status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit shifter, shared with clocked reception

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_state <= T_IDLE;
      tx_sh <= 9'h000;
      tx_cnt <= 4'h0;
      tx_tick <= 4'h0;
      txd <= 1'b1;
      sck <= 1'b1;
      clk_prev <= 1'b1;
      shift_reg_empty <= 1'b1;
    end else begin
      clk_prev <= clk_pin_in;
      if (!sync_busy)
        sck <= idle_lvl;
      else if (!clock_direction_select && brg_tick)
        sck <= ~sck;
      if (!sync_mode && !async_mode) begin
        tx_state <= T_IDLE;
        txd <= 1'b1;
        shift_reg_empty <= 1'b1;
      end else begin
        case (tx_state)
          T_IDLE: begin
            if (tx_start) begin
              tx_sh <= tx_load;
              tx_cnt <= 4'h0;
              tx_tick <= 4'h0;
              shift_reg_empty <= 1'b0;
              if (sync_mode) begin
                tx_state <= T_DATA;
              end else begin
                tx_state <= T_START;
                txd <= 1'b0;
              end
            end
          end
          T_START: begin
            if (brg_tick) begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `SU2_OVS_LAST) begin
                tx_state <= T_DATA;
                txd <= tx_bit;
              end
            end
          end
          T_DATA: begin
            if (sync_mode) begin
              if (drive_edge)
                txd <= tx_bit;
              if (sample_edge) begin
                tx_sh <= sync_next;
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == 4'h7) begin
                  tx_state <= T_IDLE;
                  shift_reg_empty <= 1'b1;
                end
              end
            end else if (brg_tick) begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `SU2_OVS_LAST) begin
                tx_sh <= tx_next;
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt == frame_len - 4'h1) begin
                  tx_state <= T_STOP;
                  txd <= 1'b1;
                end else begin
                  txd <= tx_next_bit;
                end
              end
            end
          end
          T_STOP: begin
            if (brg_tick)
              tx_tick <= tx_tick + 4'h1;
            if (async_tx_done) begin
              tx_state <= T_IDLE;
              shift_reg_empty <= 1'b1;
            end
          end
          default: tx_state <= T_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Asynchronous receiver

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_state <= T_IDLE;
      rx_sh <= 9'h000;
      rx_cnt <= 4'h0;
      rx_tick <= 4'h0;
    end else if (!async_mode || !receive_enable_bit) begin
      rx_state <= T_IDLE;
    end else begin
      if (brg_tick)
        rx_tick <= rx_tick + 4'h1;
      case (rx_state)
        T_IDLE: begin
          if (!rxd) begin
            rx_state <= T_START;
            rx_tick <= 4'h0;
            rx_cnt <= 4'h0;
          end
        end
        T_START: begin
          if (brg_tick && rx_tick == `SU2_OVS_MID) begin
            rx_tick <= 4'h0;
            rx_state <= rxd ? T_IDLE : T_DATA;
          end
        end
        T_DATA: begin
          if (brg_tick && rx_tick == `SU2_OVS_LAST) begin
            rx_sh <= rx_next;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == frame_len - 4'h1)
              rx_state <= T_STOP;
          end
        end
        T_STOP: begin
          if (rx_stop)
            rx_state <= T_IDLE;
        end
        default: rx_state <= T_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins, interrupt and read port

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_pin_out <= 1'b1;
      clk_pin_oe <= 1'b0;
      hs_pin_out <= 1'b1;
      hs_pin_oe <= 1'b0;
      hs_port_released <= 1'b0;
      err_out <= 1'b0;
      irq <= 1'b0;
      bus_rdata <= `SU2_RST_REG8;
    end else begin
      clk_pin_out <= sck;
      clk_pin_oe <= sync_mode && !clock_direction_select;
      hs_pin_out <= !(receive_enable_bit && !receive_complete);
      hs_pin_oe <= !handshake_disable && handshake_select &&
        (sync_mode || async_mode);
      hs_port_released <= handshake_disable;
      err_out <= error_output_enable && async_mode && frame_err;
      irq <= |(next_status & irq_mask);
      bus_rdata <= `SU2_RST_REG8;
      if (bus_rd) begin
        case (bus_addr)
          `SU2_ADDR_CTRL0: bus_rdata <= {bit_order_select,
            transfer_edge_polarity, 1'b0, handshake_disable,
            shift_reg_empty, handshake_select, count_source_sel_hi,
            count_source_sel_lo};
          `SU2_ADDR_CTRL1: bus_rdata <= {error_output_enable,
            data_invert_select, continuous_receive_enable,
            tx_irq_cause_select, receive_complete, receive_enable_bit,
            holding_buffer_empty, transmit_enable_bit};
          `SU2_ADDR_MODE: bus_rdata <= {4'h0, clock_direction_select,
            serial_mode};
          `SU2_ADDR_BAUD: bus_rdata <= brg_value;
          `SU2_ADDR_TXBUF: bus_rdata <= tx_hold;
          `SU2_ADDR_RXBUF: bus_rdata <= rx_buf ^ {8{data_invert_select}};
          `SU2_ADDR_STATUS: bus_rdata <= {4'h0, irq_status};
          `SU2_ADDR_MASK: bus_rdata <= {4'h0, irq_mask};
          default: bus_rdata <= `SU2_RST_REG8;
        endcase
      end
    end
  end

endmodule

/* testbench/su2_serial_ctrl_assertions.sv */
`timescale 1ns/100ps
module su2_serial_ctrl_assertions (
  input wire ref_clk,
  input wire rst,
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire txd,
  input wire clk_pin_oe,
  input wire hs_pin_oe,
  input wire hs_port_released,
  input wire err_out,
  input wire irq
);
  reg [3:0] mode_sh;
  reg [7:0] c0_sh;
  reg ere_sh;
  ////////////////////////////////////////
  // Shadow of written control fields
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_sh <= 4'h0;
      c0_sh <= 8'h00;
      ere_sh <= 1'b0;
    end else if (bus_wr) begin
      if (bus_addr == 16'h0378)
        mode_sh <= bus_wdata[3:0];
      if (bus_addr == 16'h037c)
        c0_sh <= bus_wdata;
      if (bus_addr == 16'h037d)
        ere_sh <= bus_wdata[7];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read");
  spare_bit_a: assert property (
    $past(bus_rd) && $past(bus_addr) == 16'h037c |-> !bus_rdata[5])
    else $error("spare bit reads one");
  unmapped_read_a: assert property (
    $past(bus_rd) && $past(bus_addr) == 16'h0372 |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  mode_off_idle_a: assert property (mode_sh[2:0] == 3'h0 |=> txd)
    else $error("txd active with channel off");
  port_release_a: assert property (
    hs_port_released == $past(c0_sh[4]))
    else $error("port release does not follow disable bit");
  hs_drive_a: assert property (
    hs_pin_oe |-> $past(c0_sh[2]) && !$past(c0_sh[4])
    && $past(mode_sh[2:0]) != 3'h0)
    else $error("handshake pin driven when not selected");
  clk_drive_a: assert property (clk_pin_oe |-> $past(mode_sh) == 4'h1)
    else $error("clock pin driven outside internal clocked mode");
  err_gate_a: assert property (
    err_out |-> $past(ere_sh) && $past(mode_sh[2]))
    else $error("error output outside async enable");
  irq_mask_a: assert property (
    bus_wr && bus_addr == 16'h0371 && bus_wdata == 8'h00 |-> ##2 !irq)
    else $error("interrupt with all masked");
endmodule

bind su2_serial_ctrl su2_serial_ctrl_assertions i_chk (
  .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .txd(txd), .clk_pin_oe(clk_pin_oe),
  .hs_pin_oe(hs_pin_oe), .hs_port_released(hs_port_released),
  .err_out(err_out), .irq(irq)
);

/* testbench/su2_peer_model.sv */
`timescale 1ns/100ps
module su2_peer_model (
  input wire ref_clk,
  input wire txd,
  input wire [15:0] bit_cyc,
  output reg rxd,
  output reg got,
  output reg [7:0] got_byte
);
  reg [7:0] sh;
  integer i;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_byte = 8'h00;
  end
  ////////////////////////////////////////
  // Frame decoder, mid-bit sampling, first bit to bit 0
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (bit_cyc) @(posedge ref_clk);
      sh[i] = txd;
    end
    repeat (bit_cyc) @(posedge ref_clk);
    got_byte <= sh;
    got <= 1'b1;
    @(posedge ref_clk);
    got <= 1'b0;
  end
  // Sender; a low stop bit returns high just past its middle
  task send(input [7:0] b, input stp);
    integer k;
    reg [9:0] f;
    begin
      f = {stp, b, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        rxd <= f[k];
        repeat (bit_cyc / 2 + 4) @(posedge ref_clk);
        if (k == 9)
          rxd <= 1'b1;
        repeat (bit_cyc / 2 - 4) @(posedge ref_clk);
      end
    end
  endtask
endmodule

/* testbench/su2_serial_ctrl_tb_top.sv */
`timescale 1ns/100ps
`include "su2_defines.vh"
module su2_serial_ctrl_tb_top;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] bus_addr = 16'h0000;
  reg [7:0] bus_wdata = 8'h00;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg hs_n = 1'b0;
  reg rd_d = 1'b0;
  reg [15:0] bit_cyc = 16'd32;
  wire [7:0] bus_rdata, got_byte;
  wire txd, rxd, clk_pin_out, clk_pin_oe, hs_pin_out, hs_pin_oe;
  wire hs_port_released, err_out, irq, got;
  wire [7:0] pins = {1'b0, hs_pin_out, err_out, hs_port_released, hs_pin_oe,
    clk_pin_oe, clk_pin_out, irq};
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] tx_q[$];
  integer err_total = 0;
  integer comparisons = 0;
  integer i, seed_v;
  reg [7:0] d, e;
  reg [1:0] src;

  always #2.5 ref_clk = ~ref_clk;

  su2_serial_ctrl #(.BAUD_W(8)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .rxd(rxd), .txd(txd), .clk_pin_in(1'b1),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .hs_pin_in(hs_n), .hs_pin_out(hs_pin_out), .hs_pin_oe(hs_pin_oe),
    .hs_port_released(hs_port_released), .err_out(err_out), .irq(irq)
  );
  su2_peer_model i_peer (
    .ref_clk(ref_clk), .txd(txd), .bit_cyc(bit_cyc), .rxd(rxd),
    .got(got), .got_byte(got_byte)
  );
  ////////////////////////////////////////
  task chk(input [8*8:1] nm, input [7:0] s, input [7:0] x);
    begin
      comparisons = comparisons + 1;
      if (s !== x) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, x, s);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [15:0] a, input [7:0] x, input [7:0] m);
    begin
      exp_q.push_back(x & m);
      msk_q.push_back(m);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task pk(input [7:0] x, input [7:0] m);
    begin
      @(negedge ref_clk);
      chk("pins", pins & m, x & m);
      @(posedge ref_clk);
    end
  endtask
  task drain;
    integer k;
    begin
      k = 0;
      while (tx_q.size() != 0 && k < 20000) begin
        @(posedge ref_clk);
        k = k + 1;
      end
      chk("drain", 8'(tx_q.size()), 8'h00);
      repeat (bit_cyc) @(posedge ref_clk);
    end
  endtask
  function [7:0] rev(input [7:0] v);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1)
        rev[j] = v[7 - j];
    end
  endfunction
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Result watcher: read data and bytes seen by the peer
  always @(posedge ref_clk) begin
    rd_d <= bus_rd;
    if (rd_d) begin
      chk("rdata", bus_rdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (got) begin
      if (tx_q.size() == 0)
        chk("txextra", 8'h01, 8'h00);
      else
        chk("txbyte", got_byte, tx_q.pop_front());
    end
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    $display("[ERR] watchdog exp done got hang");
    stop_test;
  end
  ////////////////////////////////////////
  initial begin
    seed_v = $urandom(55444);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL0, 8'h08, 8'hff);
    rd(`SU2_ADDR_CTRL1, 8'h02, 8'hff);
    rd(16'h0372, 8'h00, 8'hff);
    wr(`SU2_ADDR_CTRL0, 8'hdf);
    rd(`SU2_ADDR_CTRL0, 8'hdf, 8'hff);
    pk(8'h10, 8'h18);
    $display("test registers done");
    wr(`SU2_ADDR_CTRL0, 8'h00);
    wr(`SU2_ADDR_MODE, 8'h05);
    wr(`SU2_ADDR_BAUD, 8'h01);
    wr(`SU2_ADDR_MASK, 8'h01);
    for (i = 0; i < 6; i = i + 1) begin
      src = (i < 4) ? 2'd0 : 2'(i - 3);
      bit_cyc <= (src == 0) ? 16'd32 : (src == 1) ? 16'd256 : 16'd1024;
      wr(`SU2_ADDR_CTRL0, {i == 1 || i == 3, 5'h00, src});
      wr(`SU2_ADDR_CTRL1, {1'b0, i == 2 || i == 3, 6'h01});
      d = 8'($urandom);
      e = (i == 1 || i == 3) ? rev(d) : d;
      tx_q.push_back((i == 2 || i == 3) ? ~e : e);
      wr(`SU2_ADDR_STATUS, 8'h0f);
      wr(`SU2_ADDR_TXBUF, d);
      repeat (100) @(posedge ref_clk);
      rd(`SU2_ADDR_CTRL0, 8'h00, 8'h08);
      rd(`SU2_ADDR_CTRL1, 8'h02, 8'h02);
      rd(`SU2_ADDR_STATUS, 8'h01, 8'h01);
      drain;
      rd(`SU2_ADDR_CTRL0, 8'h08, 8'h08);
    end
    pk(8'h01, 8'h01);
    wr(`SU2_ADDR_MASK, 8'h00);
    pk(8'h00, 8'h01);
    wr(`SU2_ADDR_MASK, 8'h01);
    pk(8'h01, 8'h01);
    wr(`SU2_ADDR_STATUS, 8'h0f);
    pk(8'h00, 8'h01);
    $display("test transmit done");
    bit_cyc <= 16'd32;
    wr(`SU2_ADDR_CTRL0, 8'h00);
    wr(`SU2_ADDR_CTRL1, 8'h00);
    wr(`SU2_ADDR_TXBUF, 8'h5a);
    repeat (400) @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL1, 8'h00, 8'h02);
    hs_n <= 1'b1;
    wr(`SU2_ADDR_CTRL1, 8'h01);
    repeat (400) @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL1, 8'h00, 8'h02);
    tx_q.push_back(8'h5a);
    hs_n <= 1'b0;
    drain;
    wr(`SU2_ADDR_STATUS, 8'h0f);
    wr(`SU2_ADDR_CTRL1, 8'h11);
    tx_q.push_back(8'h3c);
    wr(`SU2_ADDR_TXBUF, 8'h3c);
    repeat (100) @(posedge ref_clk);
    rd(`SU2_ADDR_STATUS, 8'h00, 8'h01);
    drain;
    rd(`SU2_ADDR_STATUS, 8'h01, 8'h01);
    wr(`SU2_ADDR_MODE, 8'h04);
    d = 8'($urandom);
    tx_q.push_back({1'b1, d[6:0]});
    wr(`SU2_ADDR_TXBUF, d);
    drain;
    wr(`SU2_ADDR_MODE, 8'h05);
    $display("test enable and cause done");
    wr(`SU2_ADDR_CTRL1, 8'h44);
    pk(8'h00, 8'h40);
    d = 8'($urandom);
    i_peer.send(d, 1'b1);
    repeat (40) @(posedge ref_clk);
    pk(8'h40, 8'h40);
    rd(`SU2_ADDR_CTRL1, 8'h08, 8'h08);
    rd(`SU2_ADDR_RXBUF, ~d, 8'hff);
    rd(`SU2_ADDR_CTRL1, 8'h00, 8'h08);
    wr(`SU2_ADDR_CTRL1, 8'h00);
    i_peer.send(d, 1'b1);
    repeat (40) @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL1, 8'h00, 8'h08);
    wr(`SU2_ADDR_CTRL1, 8'h84);
    i_peer.send(8'h81, 1'b0);
    repeat (40) @(posedge ref_clk);
    pk(8'h20, 8'h20);
    rd(`SU2_ADDR_RXBUF, 8'h81, 8'hff);
    pk(8'h00, 8'h20);
    $display("test receive done");
    wr(`SU2_ADDR_CTRL1, 8'h00);
    wr(`SU2_ADDR_MODE, 8'h01);
    pk(8'h06, 8'h06);
    wr(`SU2_ADDR_CTRL1, 8'h25);
    wr(`SU2_ADDR_TXBUF, 8'hff);
    repeat (100) @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL1, 8'h08, 8'h08);
    rd(`SU2_ADDR_RXBUF, 8'hff, 8'hff);
    repeat (100) @(posedge ref_clk);
    rd(`SU2_ADDR_CTRL1, 8'h08, 8'h08);
    rd(`SU2_ADDR_CTRL0, 8'h08, 8'h08);
    wr(`SU2_ADDR_CTRL1, 8'h00);
    wr(`SU2_ADDR_CTRL0, 8'h40);
    @(posedge ref_clk);
    pk(8'h04, 8'h06);
    wr(`SU2_ADDR_MODE, 8'h09);
    pk(8'h00, 8'h04);
    wr(`SU2_ADDR_CTRL0, 8'h04);
    pk(8'h08, 8'h18);
    wr(`SU2_ADDR_CTRL0, 8'h14);
    pk(8'h10, 8'h18);
    $display("test pins done");
    stop_test;
  end
endmodule
